// *** rfscr_defines.vh ***
// Register offsets, field positions, reset values and rule summary
// Operation
// - Received address compared with node match identifier when filtering.
// - Broadcast options also accept 0x00, or 0x00 and 0xFF.
// - Slot index, unsigned 8 bit, times spacing, added to base word.
// - In receive, IF code times fxosc/2^10 subtracted; code drives mixer.
// - Trim offset is two's complement, step fxosc/2^14, added to base.
// - Carrier word bits 23:22 are read only and read zero.
// - Carrier word assembled from three bytes, unit fxosc/2^16.
// - Decimation ratio 8*(4+M)*2^E from bandwidth exponent and mantissa.
// - Symbol rate exponent sits in low nibble of bandwidth register.
// - Symbol rate word (256+M)*2^E, hidden leading one on mantissa.
// - Filter mode: none, no broadcast, 0x00 broadcast, both broadcasts.
`ifndef RFSCR_DEFINES_VH
`define RFSCR_DEFINES_VH

// ****************
// Register offsets
// ****************
`define RFSCR_NODE_MATCH 6'h09
`define RFSCR_SLOT_NUMBER 6'h0A
`define RFSCR_SYNTH_IF 6'h0B
`define RFSCR_SYNTH_TRIM 6'h0C
`define RFSCR_CARRIER_HIGH 6'h0D
`define RFSCR_CARRIER_MID 6'h0E
`define RFSCR_CARRIER_LOW 6'h0F
`define RFSCR_BW_RATE_EXP 6'h10
`define RFSCR_RATE_MANT 6'h11

// ************
// Reset values
// ************
`define RFSCR_NODE_MATCH_RST 8'h00
`define RFSCR_SLOT_NUMBER_RST 8'h00
`define RFSCR_SYNTH_IF_RST 6'h0F
`define RFSCR_SYNTH_TRIM_RST 8'h00
`define RFSCR_CARRIER_HIGH_RST 6'h1E
`define RFSCR_CARRIER_MID_RST 8'hC4
`define RFSCR_CARRIER_LOW_RST 8'hEC
`define RFSCR_BW_RATE_EXP_RST 8'h8C
`define RFSCR_RATE_MANT_RST 8'h22

// ***************
// Field positions
// ***************
`define RFSCR_IF_CODE_MSB 4
`define RFSCR_IF_RSVD_BIT 5
`define RFSCR_CARRIER_HIGH_MSB 5
`define RFSCR_BW_EXP_MSB 7
`define RFSCR_BW_EXP_LSB 6
`define RFSCR_BW_MANT_MSB 5
`define RFSCR_BW_MANT_LSB 4
`define RFSCR_RATE_EXP_MSB 3

// **************************************
// Scaling into carrier word units (2^16), bandwidth base and broadcast addresses
// **************************************
`define RFSCR_TRIM_SHIFT 2
`define RFSCR_IF_SHIFT 6
`define RFSCR_BW_BASE 3'h4
`define RFSCR_BCAST_ZERO 8'h00
`define RFSCR_BCAST_ONES 8'hFF

// ******************
// Filter mode coding
// ******************
`define RFSCR_AF_NONE 2'h0
`define RFSCR_AF_NO_BCAST 2'h1
`define RFSCR_AF_ZERO_BCAST 2'h2
`define RFSCR_AF_BOTH_BCAST 2'h3

`endif

// *** rfscr_config_regs.v ***
// Synthesizer and modem configuration register group
`timescale 1ns/1ps
`default_nettype none
`include "rfscr_defines.vh"

module rfscr_config_regs (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Control port register access
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [5:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  output reg reg_rvalid_q,
  // Operating context
  input wire rx_mode,
  input wire [15:0] slot_spacing,
  input wire [1:0] address_filter_mode,
  // Received packet address
  input wire pkt_addr_valid,
  input wire [7:0] pkt_addr,
  output reg pkt_result_valid_q,
  output reg pkt_accept_q,
  // Synthesizer and demodulator settings
  output reg [24:0] synth_word_q,
  output reg [4:0] intermediate_offset_code_q,
  output reg [23:0] carrier_word_q,
  output reg [8:0] decim_ratio_q,
  output reg [8:0] symbol_rate_mantissa_q,
  output reg [3:0] symbol_rate_exponent_q,
  output reg [23:0] symbol_rate_word_q
);

  // *****************
  // Helper functions
  // *****************
  // Accepts an address under a given filter mode
  function addr_ok;
    input [1:0] mode;
    input [7:0] addr;
    input [7:0] node;
    begin
      case (mode)
        `RFSCR_AF_NONE: addr_ok = 1'b1;
        `RFSCR_AF_NO_BCAST: addr_ok = (addr == node);
        `RFSCR_AF_ZERO_BCAST: addr_ok = (addr == node) ||
          (addr == `RFSCR_BCAST_ZERO);
        `RFSCR_AF_BOTH_BCAST: addr_ok = (addr == node) ||
          (addr == `RFSCR_BCAST_ZERO) ||
          (addr == `RFSCR_BCAST_ONES);
        default: addr_ok = 1'b0;
      endcase
    end
  endfunction

  // Write strobe for one register offset
  function wr_hit;
    input en;
    input [5:0] addr;
    input [5:0] offset;
    begin
      wr_hit = en && (addr == offset);
    end
  endfunction

  // *********
  // Registers
  // *********
  reg [7:0] node_match_q;
  reg [7:0] slot_number_q;
  reg [5:0] synth_if_q;
  reg [7:0] synth_trim_q;
  reg [5:0] carrier_high_q;
  reg [7:0] carrier_mid_q;
  reg [7:0] carrier_low_q;
  reg [7:0] bw_rate_exp_q;
  reg [7:0] rate_mant_q;

  // Write strobes, one per mapped offset
  wire node_match_wr;
  wire slot_number_wr;
  wire synth_if_wr;
  wire synth_trim_wr;
  wire carrier_high_wr;
  wire carrier_mid_wr;
  wire carrier_low_wr;
  wire bw_rate_exp_wr;
  wire rate_mant_wr;

  assign node_match_wr = wr_hit(reg_wr_en, reg_addr, `RFSCR_NODE_MATCH);
  assign slot_number_wr = wr_hit(reg_wr_en, reg_addr, `RFSCR_SLOT_NUMBER);
  assign synth_if_wr = wr_hit(reg_wr_en, reg_addr, `RFSCR_SYNTH_IF);
  assign synth_trim_wr = wr_hit(reg_wr_en, reg_addr, `RFSCR_SYNTH_TRIM);
  assign carrier_high_wr = wr_hit(reg_wr_en, reg_addr, `RFSCR_CARRIER_HIGH);
  assign carrier_mid_wr = wr_hit(reg_wr_en, reg_addr, `RFSCR_CARRIER_MID);
  assign carrier_low_wr = wr_hit(reg_wr_en, reg_addr, `RFSCR_CARRIER_LOW);
  assign bw_rate_exp_wr = wr_hit(reg_wr_en, reg_addr, `RFSCR_BW_RATE_EXP);
  assign rate_mant_wr = wr_hit(reg_wr_en, reg_addr, `RFSCR_RATE_MANT);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      node_match_q <= `RFSCR_NODE_MATCH_RST;
    end else if (node_match_wr) begin
      node_match_q <= reg_wdata;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slot_number_q <= `RFSCR_SLOT_NUMBER_RST;
    end else if (slot_number_wr) begin
      slot_number_q <= reg_wdata;
    end
  end

  // Bits 7:6 are not stored; bit 5 is a plain reserved store
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      synth_if_q <= `RFSCR_SYNTH_IF_RST;
    end else if (synth_if_wr) begin
      synth_if_q <= reg_wdata[5:0];
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      synth_trim_q <= `RFSCR_SYNTH_TRIM_RST;
    end else if (synth_trim_wr) begin
      synth_trim_q <= reg_wdata;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      carrier_high_q <= `RFSCR_CARRIER_HIGH_RST;
    end else if (carrier_high_wr) begin
      carrier_high_q <= reg_wdata[`RFSCR_CARRIER_HIGH_MSB:0];
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      carrier_mid_q <= `RFSCR_CARRIER_MID_RST;
    end else if (carrier_mid_wr) begin
      carrier_mid_q <= reg_wdata;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      carrier_low_q <= `RFSCR_CARRIER_LOW_RST;
    end else if (carrier_low_wr) begin
      carrier_low_q <= reg_wdata;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bw_rate_exp_q <= `RFSCR_BW_RATE_EXP_RST;
    end else if (bw_rate_exp_wr) begin
      bw_rate_exp_q <= reg_wdata;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rate_mant_q <= `RFSCR_RATE_MANT_RST;
    end else if (rate_mant_wr) begin
      rate_mant_q <= reg_wdata;
    end
  end

  // **********
  // Read path
  // **********
  reg [7:0] rdata_d;

  always @* begin
    case (reg_addr)
      `RFSCR_NODE_MATCH: rdata_d = node_match_q;
      `RFSCR_SLOT_NUMBER: rdata_d = slot_number_q;
      `RFSCR_SYNTH_IF: rdata_d = {2'h0, synth_if_q};
      `RFSCR_SYNTH_TRIM: rdata_d = synth_trim_q;
      `RFSCR_CARRIER_HIGH: rdata_d = {2'h0, carrier_high_q};
      `RFSCR_CARRIER_MID: rdata_d = carrier_mid_q;
      `RFSCR_CARRIER_LOW: rdata_d = carrier_low_q;
      `RFSCR_BW_RATE_EXP: rdata_d = bw_rate_exp_q;
      `RFSCR_RATE_MANT: rdata_d = rate_mant_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd_en;
    end
  end

  // Read data holds until the next read
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata_q <= rdata_d;
    end
  end

  // ******************
  // Derived settings
  // ******************
  wire [23:0] carrier_d;
  wire [24:0] trim_d;
  wire [24:0] if_sub_d;
  wire [23:0] slot_step_d;
  wire [24:0] synth_d;
  wire [1:0] bw_exp;
  wire [1:0] bw_mant;
  wire [2:0] bw_lin;
  wire [8:0] decim_d;
  wire [8:0] rate_mant_d;
  wire [23:0] rate_word_d;

  assign carrier_d = {2'h0, carrier_high_q, carrier_mid_q,
    carrier_low_q};
  // Trim step is four carrier units, sign extended
  assign trim_d = {{15{synth_trim_q[7]}}, synth_trim_q,
    2'h0};
  // IF step is 64 carrier units, only in receive
  assign if_sub_d = rx_mode ?
    {14'h0, synth_if_q[`RFSCR_IF_CODE_MSB:0], 6'h00} : 25'h0;
  assign slot_step_d = slot_number_q * slot_spacing;
  assign synth_d = {1'b0, carrier_d} + trim_d + {1'b0, slot_step_d}
    - if_sub_d;

  assign bw_exp = bw_rate_exp_q[`RFSCR_BW_EXP_MSB:`RFSCR_BW_EXP_LSB];
  assign bw_mant = bw_rate_exp_q[`RFSCR_BW_MANT_MSB:`RFSCR_BW_MANT_LSB];
  assign bw_lin = `RFSCR_BW_BASE + {1'b0, bw_mant};
  assign decim_d = {3'h0, bw_lin, 3'h0} << bw_exp;

  assign rate_mant_d = {1'b1, rate_mant_q};
  assign rate_word_d = {15'h0, rate_mant_d} <<
    bw_rate_exp_q[`RFSCR_RATE_EXP_MSB:0];

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      synth_word_q <= 25'h0;
    end else begin
      synth_word_q <= synth_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      intermediate_offset_code_q <= 5'h0;
    end else begin
      intermediate_offset_code_q <=
        synth_if_q[`RFSCR_IF_CODE_MSB:0];
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      carrier_word_q <= 24'h0;
    end else begin
      carrier_word_q <= carrier_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      decim_ratio_q <= 9'h0;
    end else begin
      decim_ratio_q <= decim_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      symbol_rate_mantissa_q <= 9'h0;
    end else begin
      symbol_rate_mantissa_q <= rate_mant_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      symbol_rate_exponent_q <= 4'h0;
    end else begin
      symbol_rate_exponent_q <=
        bw_rate_exp_q[`RFSCR_RATE_EXP_MSB:0];
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      symbol_rate_word_q <= 24'h0;
    end else begin
      symbol_rate_word_q <= rate_word_d;
    end
  end

  // ****************
  // Address filter
  // ****************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pkt_result_valid_q <= 1'b0;
    end else begin
      pkt_result_valid_q <= pkt_addr_valid;
    end
  end

  // Decision holds until the next received address
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pkt_accept_q <= 1'b0;
    end else if (pkt_addr_valid) begin
      pkt_accept_q <= addr_ok(address_filter_mode, pkt_addr,
        node_match_q);
    end
  end

endmodule // rfscr_config_regs
`default_nettype wire

// *** rfscr_host.sv ***
// Host model driving the parallel register port
`timescale 1ns/1ps
`default_nettype none
module rfscr_host (
  // Register port
  input wire logic clk,
  output logic wr_en = 1'b0,
  output logic rd_en = 1'b0,
  output logic [5:0] addr = 6'h00,
  output logic [7:0] wdata = 8'h00,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d,
    output logic v);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
    v = rvalid;
  endtask
endmodule // rfscr_host
`default_nettype wire

// *** rfscr_config_props.sv ***
// Checker for the configuration register group
`timescale 1ns/1ps
`default_nettype none
module rfscr_config_props (
  // Watched ports
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  input wire logic [1:0] address_filter_mode,
  input wire logic pkt_addr_valid,
  input wire logic [7:0] pkt_addr,
  input wire logic pkt_result_valid_q,
  input wire logic pkt_accept_q,
  input wire logic [23:0] carrier_word_q,
  input wire logic [8:0] symbol_rate_mantissa_q,
  input wire logic [3:0] symbol_rate_exponent_q,
  input wire logic [23:0] symbol_rate_word_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  read_answer_a: assert property (reg_rd_en |=> reg_rvalid_q)
    else $error("read not answered");
  read_quiet_a: assert property (!reg_rd_en |=>
    !reg_rvalid_q && $stable(reg_rdata_q)) else $error("read data moved");
  pkt_answer_a: assert property (pkt_addr_valid |=> pkt_result_valid_q)
    else $error("packet not answered");
  pkt_hold_a: assert property (!pkt_addr_valid |=>
    !pkt_result_valid_q && $stable(pkt_accept_q)) else $error("accept moved");
  open_mode_a: assert property (pkt_addr_valid &&
    address_filter_mode == 2'h0 |=> pkt_accept_q) else $error("open refused");
  bcast_ones_a: assert property (pkt_addr_valid && pkt_addr == 8'hFF &&
    address_filter_mode == 2'h3 |=> pkt_accept_q) else $error("FF refused");
  bcast_zero_a: assert property (pkt_addr_valid && pkt_addr == 8'h00 &&
    address_filter_mode[1] |=> pkt_accept_q) else $error("00 refused");
  carrier_top_a: assert property (carrier_word_q[23:22] == 2'h0)
    else $error("carrier top bits set");
  hidden_one_a: assert property ($past(resetn) |->
    symbol_rate_mantissa_q[8]) else $error("hidden one missing");
  rate_word_a: assert property (symbol_rate_word_q ==
    (24'(symbol_rate_mantissa_q) << symbol_rate_exponent_q))
    else $error("rate word wrong");
endmodule // rfscr_config_props
bind rfscr_config_regs rfscr_config_props props (.clk(clk), .resetn(resetn),
  .reg_rd_en(reg_rd_en), .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q), .address_filter_mode(address_filter_mode),
  .pkt_addr_valid(pkt_addr_valid), .pkt_addr(pkt_addr),
  .pkt_result_valid_q(pkt_result_valid_q), .pkt_accept_q(pkt_accept_q),
  .carrier_word_q(carrier_word_q),
  .symbol_rate_mantissa_q(symbol_rate_mantissa_q),
  .symbol_rate_exponent_q(symbol_rate_exponent_q),
  .symbol_rate_word_q(symbol_rate_word_q));
`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench for the configuration register group
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, resetn = 1'b0, rx_mode = 1'b0, pv = 1'b0, v;
  logic [15:0] spacing = 16'h0000;
  logic [1:0] mode = 2'h0;
  logic [7:0] pa = 8'h00, d;
  logic wr_en, rd_en, rvalid, prv, acc;
  logic [5:0] addr;
  logic [7:0] wdata, rdata;
  logic [24:0] synth;
  logic [4:0] ifc;
  logic [23:0] carrier, rword;
  logic [8:0] decim, mant;
  logic [3:0] rexp;
  int fails = 0, checked = 0, cyc = 0;
  logic [5:0] ra [10] = '{6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F,
    6'h10, 6'h11, 6'h00};
  logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h0F, 8'h00, 8'h1E, 8'hC4, 8'hEC,
    8'h8C, 8'h22, 8'h00};
  logic [7:0] pt [4] = '{8'h5A, 8'h00, 8'hFF, 8'h33};
  always #5 clk = ~clk;
  rfscr_host host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rvalid(rvalid));
  rfscr_config_regs uut (.clk(clk), .resetn(resetn), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata_q(rdata), .reg_rvalid_q(rvalid), .rx_mode(rx_mode),
    .slot_spacing(spacing), .address_filter_mode(mode),
    .pkt_addr_valid(pv), .pkt_addr(pa), .pkt_result_valid_q(prv),
    .pkt_accept_q(acc), .synth_word_q(synth),
    .intermediate_offset_code_q(ifc), .carrier_word_q(carrier),
    .decim_ratio_q(decim), .symbol_rate_mantissa_q(mant),
    .symbol_rate_exponent_q(rexp), .symbol_rate_word_q(rword));
  task automatic chk(string n, logic [24:0] e, logic [24:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      host.rd(ra[i], d, v);
      chk("reset read", 25'(rv[i]), 25'(d));
      chk("rvalid", 25'h1, 25'(v));
    end
    chk("carrier", 25'h1EC4EC, 25'(carrier));
    chk("decim", 25'h80, 25'(decim));
    chk("rate word", 25'h122000, 25'(rword));
    chk("rate mant", 25'h122, 25'(mant));
    $display("reset test done");
    host.wr(6'h0D, 8'hFF);
    host.rd(6'h0D, d, v);
    chk("carrier high", 25'h3F, 25'(d));
    host.wr(6'h0B, 8'hFF);
    host.rd(6'h0B, d, v);
    chk("if reg", 25'h3F, 25'(d));
    host.wr(6'h0B, 8'h0F);
    host.wr(6'h0D, 8'h10);
    host.wr(6'h0E, 8'h00);
    host.wr(6'h0F, 8'h00);
    host.wr(6'h0C, 8'hFF);
    host.wr(6'h0A, 8'h03);
    spacing <= 16'h0100;
    repeat (3) @(posedge clk);
    #1 chk("synth tx", 25'h1002FC, synth);
    @(posedge clk) rx_mode <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("synth rx", 25'h0FFF3C, synth);
    chk("if code", 25'h0F, 25'(ifc));
    $display("synth test done");
    host.wr(6'h10, 8'hF5);
    host.wr(6'h11, 8'hFF);
    repeat (3) @(posedge clk);
    #1 chk("decim", 25'h1C0, 25'(decim));
    chk("rate exp", 25'h5, 25'(rexp));
    chk("rate word", 25'h3FE0, 25'(rword));
    chk("rate mant", 25'h1FF, 25'(mant));
    $display("modem test done");
    host.wr(6'h09, 8'h5A);
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        mode <= 2'(m);
        pv <= 1'b1;
        pa <= pt[k];
        @(posedge clk);
        pv <= 1'b0;
        pa <= ~pt[k];
        #1 chk("result valid", 25'h1, 25'(prv));
        chk("accept", 25'(m == 0 || k == 0 || (m >= 2 && k == 1) ||
          (m == 3 && k == 2)), 25'(acc));
      end
    end
    $display("filter test done");
    // Reset again mid-run: written registers must return to defaults
    @(posedge clk) resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    host.rd(6'h09, d, v);
    chk("node after reset", 25'h00, 25'(d));
    chk("carrier after reset", 25'h1EC4EC, 25'(carrier));
    $display("second reset test done");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
